/* File: rtl/pll_ref_switch_and_dividers.sv */
/*
  PLL front end: reference selection (manual or automatic revertive),
  switchover deglitch, loss monitor, reference and feedback dividers,
  register port. Assumes reference, feedback and pin inputs are
  asynchronous and slower than half of clk.
*/
`timescale 1ns/1ps
module pll_ref_switch_and_dividers #(
  parameter int REF_LOSS_CYC = pll_front_pkg::REF_LOSS_CYC_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  output logic [7:0] reg_rdata_ff,
  // reference and feedback clocks
  input wire logic primary_reference,
  input wire logic secondary_reference,
  input wire logic vco_feedback,
  // control pins
  input wire logic reference_choice_pin,
  input wire logic sync_pin_n,
  // status pins
  output logic reference_monitor_pin,
  output logic status_pin,
  output logic secondary_active_ff,
  // phase detector inputs
  output logic phase_detector_ref,
  output logic phase_detector_fb
);

  initial begin
    if (REF_LOSS_CYC < 2 || REF_LOSS_CYC > 65535) begin
      $error("REF_LOSS_CYC out of range");
    end
  end

  function automatic logic rise(logic prev, logic cur);
    return cur && !prev;
  endfunction

  // registers
  logic [7:0] ref_div_low_ff, ref_div_high_ff, a_count_ff;
  logic [7:0] b_count_low_ff, b_count_high_ff, prescaler_ff;
  logic [7:0] sync_ctrl_ff, monitor_ff, ref_select_ff, cnt_reset_ff;

  wire hit_rl = reg_addr == pll_front_pkg::OFS_REF_DIV_LOW;
  wire hit_rh = reg_addr == pll_front_pkg::OFS_REF_DIV_HIGH;
  wire hit_a = reg_addr == pll_front_pkg::OFS_A_COUNT;
  wire hit_bl = reg_addr == pll_front_pkg::OFS_B_COUNT_LOW;
  wire hit_bh = reg_addr == pll_front_pkg::OFS_B_COUNT_HIGH;
  wire hit_ps = reg_addr == pll_front_pkg::OFS_PRESCALER;
  wire hit_sy = reg_addr == pll_front_pkg::OFS_SYNC_CTRL;
  wire hit_mo = reg_addr == pll_front_pkg::OFS_MONITOR;
  wire hit_rs = reg_addr == pll_front_pkg::OFS_REF_SELECT;
  wire hit_cr = reg_addr == pll_front_pkg::OFS_CNT_RESET;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ref_div_low_ff <= pll_front_pkg::REG_RESET_VAL;
      ref_div_high_ff <= pll_front_pkg::REG_RESET_VAL;
      a_count_ff <= pll_front_pkg::REG_RESET_VAL;
      b_count_low_ff <= pll_front_pkg::REG_RESET_VAL;
      b_count_high_ff <= pll_front_pkg::REG_RESET_VAL;
      prescaler_ff <= pll_front_pkg::REG_RESET_VAL;
      sync_ctrl_ff <= pll_front_pkg::REG_RESET_VAL;
      monitor_ff <= pll_front_pkg::REG_RESET_VAL;
      ref_select_ff <= pll_front_pkg::REG_RESET_VAL;
      cnt_reset_ff <= pll_front_pkg::REG_RESET_VAL;
    end else if (reg_wr) begin
      if (hit_rl) begin
        ref_div_low_ff <= reg_wdata;
      end else if (hit_rh) begin
        ref_div_high_ff <= reg_wdata;
      end else if (hit_a) begin
        a_count_ff <= reg_wdata;
      end else if (hit_bl) begin
        b_count_low_ff <= reg_wdata;
      end else if (hit_bh) begin
        b_count_high_ff <= reg_wdata;
      end else if (hit_ps) begin
        prescaler_ff <= reg_wdata;
      end else if (hit_sy) begin
        sync_ctrl_ff <= reg_wdata;
      end else if (hit_mo) begin
        monitor_ff <= reg_wdata;
      end else if (hit_rs) begin
        ref_select_ff <= reg_wdata;
      end else if (hit_cr) begin
        // reset bits stay set until software writes them back to zero
        cnt_reset_ff <= reg_wdata;
      end
    end
  end

  // read data: unused divider and prescaler bits and unmapped offsets read as zero; spare bits read back
  logic [7:0] rd_mux;
  assign rd_mux = hit_rl ? ref_div_low_ff :
                  hit_rh ? {2'h0, ref_div_high_ff[5:0]} :
                  hit_a ? {2'h0, a_count_ff[5:0]} :
                  hit_bl ? b_count_low_ff :
                  hit_bh ? {3'h0, b_count_high_ff[4:0]} :
                  hit_ps ? {5'h00, prescaler_ff[2:0]} :
                  hit_sy ? sync_ctrl_ff :
                  hit_mo ? monitor_ff :
                  hit_rs ? ref_select_ff :
                  hit_cr ? cnt_reset_ff : 8'h00;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata_ff <= 8'h00;
    end else begin
      reg_rdata_ff <= rd_mux;
    end
  end

  pll_front_pkg::refsel_s sel_cfg;
  pll_front_pkg::cnt_reset_s rst_cfg;
  pll_front_pkg::fb_cfg_s fb_cfg;
  assign sel_cfg = ref_select_ff;
  assign rst_cfg = cnt_reset_ff;
  assign fb_cfg = '{b: {b_count_high_ff[4:0], b_count_low_ff},
                    a: a_count_ff[5:0], mode: prescaler_ff[2:0]};

  // pin synchronisers: meta_ff is read only by sync_ff
  logic [4:0] meta_ff, sync_ff, prev_ff;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_ff <= 5'h1f;
      sync_ff <= 5'h1f;
      prev_ff <= 5'h1f;
    end else begin
      meta_ff <= {sync_pin_n, reference_choice_pin, vco_feedback,
                  secondary_reference, primary_reference};
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  wire pri_rise = rise(prev_ff[0], sync_ff[0]);
  wire sec_rise = rise(prev_ff[1], sync_ff[1]);
  wire vco_rise = rise(prev_ff[2], sync_ff[2]);
  wire choice_lvl = sync_ff[3];
  wire sync_fall = rise(sync_ff[4], prev_ff[4]);

  wire pri_edge = pri_rise && (sel_cfg.primary_on || sel_cfg.differential);
  wire sec_edge = sec_rise && sel_cfg.secondary_on && !sel_cfg.differential;

  // loss monitor: a reference is invalid after REF_LOSS_CYC idle cycles
  logic [15:0] idle_ff [2];
  logic [1:0] invalid;
  wire [1:0] ref_seen = {sec_edge, pri_edge};
  always_ff @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (sys_rst || ref_seen[i]) begin
        idle_ff[i] <= 16'h0000;
      end else if (!invalid[i]) begin
        idle_ff[i] <= idle_ff[i] + 16'h0001;
      end
    end
  end
  assign invalid[0] = idle_ff[0] >= 16'(REF_LOSS_CYC);
  assign invalid[1] = idle_ff[1] >= 16'(REF_LOSS_CYC);

  // monitor and status pins
  wire [4:0] mon_src = monitor_ff[pll_front_pkg::MON_SRC_HI:0];
  wire pref_invalid = sel_cfg.prefer_secondary ? invalid[1] : invalid[0];
  wire mon_nxt = (mon_src == pll_front_pkg::MON_SRC_PRI_INVALID) ? invalid[0]
               : (mon_src == pll_front_pkg::MON_SRC_SEC_INVALID) ? invalid[1]
               : 1'b0;
  wire status_nxt = rst_cfg.status_auto && pref_invalid;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reference_monitor_pin <= 1'b0;
      status_pin <= 1'b0;
    end else begin
      reference_monitor_pin <= mon_nxt;
      status_pin <= status_nxt;
    end
  end

  // selection; automatic mode leaves the preferred input only while the
  // pin says it is invalid, so it is always revertive
  wire auto_cmd = rst_cfg.status_auto ? status_pin : reference_monitor_pin;
  wire manual_sel = sel_cfg.pin_select ? choice_lvl
                  : sel_cfg.manual_secondary;
  wire want_sec = sel_cfg.differential ? 1'b0
                : sel_cfg.auto_enable ? (sel_cfg.prefer_secondary ^ auto_cmd)
                : manual_sel;
  wire switching = want_sec != secondary_active_ff;

  // deglitch: after a switch, drop edges until the new input shows one;
  // with no clock on the target this lasts until deglitch_off is set, by design
  pll_front_pkg::deglitch_e dg_ff, nxt_dg;
  wire new_edge = want_sec ? sec_edge : pri_edge;
  always_comb begin
    nxt_dg = dg_ff;
    case (dg_ff)
      pll_front_pkg::DG_PASS: begin
        if (switching && !sel_cfg.deglitch_off) begin
          nxt_dg = pll_front_pkg::DG_WAIT;
        end
      end
      pll_front_pkg::DG_WAIT: begin
        if (sel_cfg.deglitch_off || (new_edge && !switching)) begin
          nxt_dg = pll_front_pkg::DG_PASS;
        end
      end
      default: nxt_dg = pll_front_pkg::DG_PASS;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dg_ff <= pll_front_pkg::DG_PASS;
      secondary_active_ff <= 1'b0;
    end else begin
      dg_ff <= nxt_dg;
      secondary_active_ff <= want_sec;
    end
  end

  wire sel_edge = secondary_active_ff ? sec_edge : pri_edge;
  wire gated_edge = sel_edge && !switching
                  && dg_ff == pll_front_pkg::DG_PASS;

  // divider holds: own bit, shared bit, or sync pin when enabled
  wire [1:0] sync_mode = sync_ctrl_ff[pll_front_pkg::SYNC_FIELD_HI:
                                      pll_front_pkg::SYNC_FIELD_LO];
  wire sync_hold = (sync_mode == pll_front_pkg::SYNC_EDGE) ? sync_fall
                 : (sync_mode != pll_front_pkg::SYNC_OFF) && !sync_ff[4];
  wire ref_hold = rst_cfg.ref_rst || rst_cfg.shared_rst
                || sync_hold;
  wire fb_hold = rst_cfg.fb_rst || rst_cfg.shared_rst || sync_hold;

  ref_divider #(
    .W(pll_front_pkg::REF_DIV_W)
  ) u_ref_div (
    .clk(clk),
    .sys_rst(sys_rst),
    .hold(ref_hold),
    .ratio({ref_div_high_ff[5:0], ref_div_low_ff}),
    .ref_edge(gated_edge),
    .div_pulse_ff(phase_detector_ref)
  );

  feedback_divider u_fb_div (
    .clk(clk),
    .sys_rst(sys_rst),
    .hold(fb_hold),
    .cfg(fb_cfg),
    .fb_edge(vco_rise),
    .div_pulse_ff(phase_detector_fb)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_switch_req;
    switching && !sel_cfg.deglitch_off && dg_ff == pll_front_pkg::DG_PASS;
  endsequence

  a_deglitch_enter: assert property (
    s_switch_req |=> dg_ff == pll_front_pkg::DG_WAIT)
    else $error("deglitch did not arm on switch");
  a_deglitch_blocks: assert property (
    dg_ff == pll_front_pkg::DG_WAIT |=> !phase_detector_ref)
    else $error("edge passed while deglitch waits");
  a_wait_holds: assert property (
    dg_ff == pll_front_pkg::DG_WAIT && !new_edge && !sel_cfg.deglitch_off
    |=> dg_ff == pll_front_pkg::DG_WAIT)
    else $error("deglitch left wait without target edge");
  a_monitor_pri: assert property (
    mon_src == pll_front_pkg::MON_SRC_PRI_INVALID && $stable(mon_src)
    |=> reference_monitor_pin == $past(invalid[0]))
    else $error("monitor pin does not follow primary loss");
  a_auto_revert: assert property (
    sel_cfg.auto_enable && !sel_cfg.differential && !rst_cfg.status_auto
    && !sel_cfg.prefer_secondary && !reference_monitor_pin
    |=> !secondary_active_ff)
    else $error("automatic mode did not return to preferred");
  a_manual_pin: assert property (
    !sel_cfg.auto_enable && sel_cfg.pin_select && !sel_cfg.differential
    |=> secondary_active_ff == $past(choice_lvl))
    else $error("choice pin not followed");
  a_ref_hold_quiet: assert property (
    ref_hold ##1 ref_hold |-> !phase_detector_ref)
    else $error("reference divider pulsed while held");
  a_fb_hold_quiet: assert property (
    fb_hold ##1 fb_hold |-> !phase_detector_fb)
    else $error("feedback divider pulsed while held");
  a_ref_div_one: assert property (
    ({ref_div_high_ff[5:0], ref_div_low_ff} < 14'h0002) && !ref_hold
    && gated_edge |=> phase_detector_ref)
    else $error("divide by one missed an edge");

endmodule

/* File: include/pll_front_pkg.sv */
/*
  Shared constants and types for the PLL front end: register offsets,
  field positions, reset values, prescaler and sync modes, carriers.
  Assumes an 8-bit register port with byte offsets as listed here.
*/
package pll_front_pkg;

  // register offsets
  localparam logic [7:0] OFS_REF_DIV_LOW = 8'h11;
  localparam logic [7:0] OFS_REF_DIV_HIGH = 8'h12;
  localparam logic [7:0] OFS_A_COUNT = 8'h13;
  localparam logic [7:0] OFS_B_COUNT_LOW = 8'h14;
  localparam logic [7:0] OFS_B_COUNT_HIGH = 8'h15;
  localparam logic [7:0] OFS_PRESCALER = 8'h16;
  localparam logic [7:0] OFS_SYNC_CTRL = 8'h19;
  localparam logic [7:0] OFS_MONITOR = 8'h1b;
  localparam logic [7:0] OFS_REF_SELECT = 8'h1c;
  localparam logic [7:0] OFS_CNT_RESET = 8'h1f;

  // values after reset: references off, sync reset disabled
  localparam logic [7:0] REG_RESET_VAL = 8'h00;

  // field layout
  localparam int REF_DIV_W = 14;
  localparam int A_W = 6;
  localparam int B_W = 13;
  localparam int N_W = 19;
  localparam int SYNC_FIELD_HI = 7;
  localparam int SYNC_FIELD_LO = 6;
  localparam int MON_SRC_HI = 4;

  // monitor pin sources
  localparam logic [4:0] MON_SRC_PRI_INVALID = 5'h17;
  localparam logic [4:0] MON_SRC_SEC_INVALID = 5'h18;

  // sync pin reset modes
  localparam logic [1:0] SYNC_OFF = 2'h0;
  localparam logic [1:0] SYNC_EDGE = 2'h2;

  // prescaler modes: dual modulus P/P+1 for 0..4, fixed divide 5..7
  localparam logic [2:0] PS_DM_2 = 3'h0;
  localparam logic [2:0] PS_DM_32 = 3'h4;
  localparam logic [2:0] PS_FD_1 = 3'h5;
  localparam logic [2:0] PS_FD_2 = 3'h6;

  // default reference loss timeout in clk cycles, used for both references
  localparam int REF_LOSS_CYC_DEF = 256;

  typedef struct packed {
    logic deglitch_off;
    logic manual_secondary;
    logic auto_enable;
    logic pin_select;
    logic prefer_secondary;
    logic secondary_on;
    logic primary_on;
    logic differential;
  } refsel_s;

  typedef struct packed {
    logic [3:0] spare;
    logic status_auto;
    logic shared_rst;
    logic fb_rst;
    logic ref_rst;
  } cnt_reset_s;

  typedef struct packed {
    logic [B_W-1:0] b;
    logic [A_W-1:0] a;
    logic [2:0] mode;
  } fb_cfg_s;

  typedef enum logic [1:0] {
    DG_PASS = 2'b01,
    DG_WAIT = 2'b10
  } deglitch_e;

endpackage

/* File: rtl/ref_divider.sv */
/*
  Reference divider: counts qualified reference edges, emits a one-cycle
  pulse toward the phase detector every R edges.
  Assumes edge pulses already synchronised to clk.
*/
`timescale 1ns/1ps
module ref_divider #(
  parameter int W = pll_front_pkg::REF_DIV_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // control
  input wire logic hold,
  input wire logic [W-1:0] ratio,
  // edges
  input wire logic ref_edge,
  output logic div_pulse_ff
);

  initial begin
    if (W < 2) begin
      $error("ref_divider width too small");
    end
  end

  logic [W-1:0] cnt_ff;
  logic [W-1:0] last;
  logic wrap;

  // settings of zero and one both divide by one
  assign last = (ratio < W'(2)) ? '0 : ratio - W'(1);
  assign wrap = (cnt_ff >= last);

  always_ff @(posedge clk) begin
    if (sys_rst || hold) begin
      cnt_ff <= '0;
      div_pulse_ff <= 1'b0;
    end else begin
      div_pulse_ff <= ref_edge && wrap;
      if (ref_edge) begin
        cnt_ff <= wrap ? '0 : cnt_ff + W'(1);
      end
    end
  end

endmodule

/* File: rtl/feedback_divider.sv */
/*
  Feedback divider N = P*B + A in dual modulus, P*B in fixed divide.
  Modelled as one counter over feedback edges at the computed total.
  Assumes feedback edges already synchronised to clk.
*/
`timescale 1ns/1ps
module feedback_divider (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // control
  input wire logic hold,
  input wire pll_front_pkg::fb_cfg_s cfg,
  // edges
  input wire logic fb_edge,
  output logic div_pulse_ff
);

  localparam int NW = pll_front_pkg::N_W;

  function automatic logic [NW-1:0] total_div(pll_front_pkg::fb_cfg_s c);
    logic [NW-1:0] p;
    logic [NW-1:0] n;
    p = '0;
    n = '0;
    if (c.mode <= pll_front_pkg::PS_DM_32) begin
      p = NW'(2) << c.mode;
      n = NW'(p * NW'(c.b)) + NW'(c.a);
    end else begin
      p = NW'(c.mode - pll_front_pkg::PS_FD_1) + NW'(1);
      n = NW'(p * NW'(c.b));
    end
    // b of zero is illegal; a total of zero is forced to divide by one
    if (n == '0) begin
      n = NW'(1);
    end
    return n;
  endfunction

  logic [NW-1:0] n_total;
  logic [NW-1:0] cnt_ff;
  logic wrap;

  // b of one takes no bypass; the counter runs at the computed total
  assign n_total = total_div(cfg);
  assign wrap = (cnt_ff >= n_total - NW'(1));

  always_ff @(posedge clk) begin
    if (sys_rst || hold) begin
      cnt_ff <= '0;
      div_pulse_ff <= 1'b0;
    end else begin
      div_pulse_ff <= fb_edge && wrap;
      if (fb_edge) begin
        cnt_ff <= wrap ? '0 : cnt_ff + NW'(1);
      end
    end
  end

endmodule

/* File: sim/ref_source_model.sv */
/*
  Far-side model: two single-ended reference clocks and the external
  VCO feedback clock. Each runs only while its run input is high.
  Assumes the bench keeps the half period a whole multiple of clk.
*/
`timescale 1ns/1ps
module ref_source_model #(
  parameter int HALF_NS = 60
) (
  // run controls
  input wire logic run_pri,
  input wire logic run_sec,
  input wire logic run_vco,
  // clocks
  output logic primary_reference,
  output logic secondary_reference,
  output logic vco_feedback
);
  initial begin
    primary_reference = 1'b0;
    secondary_reference = 1'b0;
    vco_feedback = 1'b0;
  end

  // a stopped source stands low, as a dc-coupled cmos driver would
  // the secondary keeps toggling only while run_sec is high
  always #(HALF_NS) begin
    primary_reference <= run_pri ? ~primary_reference : 1'b0;
    secondary_reference <= run_sec ? ~secondary_reference : 1'b0;
    vco_feedback <= run_vco ? ~vco_feedback : 1'b0;
  end
endmodule

/* File: sim/pll_ref_switch_and_dividers_tb_top.sv */
/*
  Self-checking bench for the PLL front end: registers, dividers,
  counter resets, manual and automatic reference switching.
  Assumes the source model clocks at six clk periods.
*/
`timescale 1ns/1ps
module pll_ref_switch_and_dividers_tb_top;
  localparam int PER = 6;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_rdata_ff;
  logic pri, sec, vco;
  logic run_pri = 1'b1;
  logic run_sec = 1'b1;
  logic run_vco = 1'b1;
  logic reference_choice_pin = 1'b0;
  logic sync_pin_n = 1'b1;
  logic reference_monitor_pin, status_pin, secondary_active_ff;
  logic phase_detector_ref, phase_detector_fb;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n_ref = 0;
  int n_fb = 0;

  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (phase_detector_ref === 1'b1) n_ref <= n_ref + 1;
    if (phase_detector_fb === 1'b1) n_fb <= n_fb + 1;
  end

  ref_source_model src (.run_pri(run_pri), .run_sec(run_sec),
    .run_vco(run_vco), .primary_reference(pri),
    .secondary_reference(sec), .vco_feedback(vco));

  pll_ref_switch_and_dividers #(.REF_LOSS_CYC(16)) dut (.clk(clk),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rdata_ff(reg_rdata_ff),
    .primary_reference(pri), .secondary_reference(sec),
    .vco_feedback(vco), .reference_choice_pin(reference_choice_pin),
    .sync_pin_n(sync_pin_n),
    .reference_monitor_pin(reference_monitor_pin),
    .status_pin(status_pin), .secondary_active_ff(secondary_active_ff),
    .phase_detector_ref(phase_detector_ref),
    .phase_detector_fb(phase_detector_fb));

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1 reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1 reg_addr = a;
    @(posedge clk);
    #1 d = reg_rdata_ff;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // clk cycles between two later pulses of the chosen divider output
  task automatic gap(input bit fb, output int g);
    int t0;
    int k;
    t0 = 0;
    for (k = 0; k < 3; k++) begin
      g = 0;
      while ((fb ? phase_detector_fb : phase_detector_ref) !== 1'b1 &&
             g < 20000) begin
        @(negedge clk);
        g++;
      end
      if (k == 2) g = cyc - t0;
      t0 = cyc;
      @(negedge clk);
    end
  endtask

  function automatic int n_expect(input int mode, input int a, input int b);
    int n;
    if (mode < 5) n = (2 << mode) * b + a;
    else n = (mode - 4) * b;
    return (n == 0) ? 1 : n;
  endfunction

  initial begin
    #1_000_000;
    n_fail++;
    close_out();
  end

  initial begin
    logic [7:0] d;
    logic [7:0] ofs [5] = '{8'h11, 8'h12, 8'h16, 8'h1b, 8'h1c};
    logic [7:0] msk [5] = '{8'hff, 8'h3f, 8'h07, 8'hff, 8'hff};
    int g, r, m, a, b, c0, f0;
    void'($urandom(14434));
    wait_cyc(6);
    sys_rst = 1'b0;
    // reset values, readback of stored fields, unmapped offset
    for (int i = 0; i < 5; i++) begin
      rd(ofs[i], d);
      check(d, 8'h00);
      m = $urandom;
      wr(ofs[i], m[7:0]);
      rd(ofs[i], d);
      check(d, m[7:0] & msk[i]);
    end
    wr(8'h40, 8'h5a);
    rd(8'h40, d);
    check(d, 8'h00);
    $display("test registers done");
    // reference divider ratios, zero and one both divide by one
    wr(8'h1c, 8'h02);
    wr(8'h12, 8'h00);
    for (int i = 0; i < 6; i++) begin
      r = (i < 2) ? i : 2 + $urandom % 40;
      wr(8'h11, r[7:0]);
      gap(0, g);
      check(g, PER * ((r < 2) ? 1 : r));
    end
    $display("test reference divider done");
    // every prescaler mode with legal A and B, plus B of one in fixed divide 2
    for (int mode = 0; mode < 9; mode++) begin
      b = (mode == 8) ? 1 : 3 + $urandom % 4;
      a = (mode == 8) ? 0 : $urandom % (b + 1);
      wr(8'h13, a[7:0]);
      wr(8'h14, b[7:0]);
      wr(8'h15, 8'h00);
      wr(8'h16, (mode == 8) ? 8'h06 : mode[7:0]);
      gap(1, g);
      check(g, PER * n_expect((mode == 8) ? 6 : mode, a, b));
    end
    $display("test feedback divider done");
    // reset bits hold counters silent until cleared
    for (int i = 0; i < 3; i++) begin
      wr(8'h1f, 8'h01 << i);
      wait_cyc(5);
      c0 = n_ref;
      f0 = n_fb;
      wait_cyc(300);
      check((n_ref - c0) > 0, i == 1);
      check(status_pin, 1'b0);
      check((n_fb - f0) > 0, i == 0);
    end
    wr(8'h1f, 8'h00);
    wait_cyc(300);
    check(n_ref > c0, 1'b1);
    $display("test counter reset done");
    // sync pin: ignored by default, holds all counters when enabled
    for (int i = 0; i < 2; i++) begin
      if (i == 1) wr(8'h19, 8'h40);
      sync_pin_n = 1'b0;
      wait_cyc(5);
      c0 = n_ref;
      f0 = n_fb;
      wait_cyc(300);
      check((n_ref - c0) > 0, i == 0);
      check((n_fb - f0) > 0, i == 0);
      sync_pin_n = 1'b1;
    end
    wr(8'h19, 8'h00);
    $display("test sync pin done");
    // manual selection by register bit and by choice pin
    wr(8'h1c, 8'h46);
    wait_cyc(4);
    check(secondary_active_ff, 1'b1);
    wr(8'h1c, 8'h16);
    for (int i = 0; i < 4; i++) begin
      reference_choice_pin = i[0];
      wait_cyc(8);
      check(secondary_active_ff, i[0]);
    end
    reference_choice_pin = 1'b0;
    $display("test manual switch done");
    // automatic revertive switching on primary loss
    wr(8'h1b, 8'hf7);
    wr(8'h1c, 8'h26);
    wait_cyc(30);
    check({reference_monitor_pin, secondary_active_ff}, 2'b00);
    run_pri = 1'b0;
    wait_cyc(60);
    check({reference_monitor_pin, secondary_active_ff}, 2'b11);
    gap(0, g);
    check(g, PER * r);
    run_pri = 1'b1;
    wait_cyc(60);
    check({reference_monitor_pin, secondary_active_ff}, 2'b00);
    // secondary preferred, switch away while it is lost
    wr(8'h1b, 8'hf8);
    wr(8'h1c, 8'h2e);
    wait_cyc(30);
    check(secondary_active_ff, 1'b1);
    run_sec = 1'b0;
    wait_cyc(60);
    check({reference_monitor_pin, secondary_active_ff}, 2'b10);
    run_sec = 1'b1;
    wait_cyc(60);
    check({reference_monitor_pin, secondary_active_ff}, 2'b01);
    // status pin drives the switch, primary preferred
    wr(8'h1f, 8'h08);
    wr(8'h1c, 8'h26);
    wait_cyc(30);
    check({status_pin, secondary_active_ff}, 2'b00);
    run_pri = 1'b0;
    wait_cyc(60);
    check({status_pin, secondary_active_ff}, 2'b11);
    run_pri = 1'b1;
    wait_cyc(60);
    check({status_pin, secondary_active_ff}, 2'b00);
    wr(8'h1f, 8'h00);
    $display("test automatic switch done");
    close_out();
  end
endmodule
